// [verilog/fbm_pkg.sv]
// Purpose: shared constants and carriers for the flag bit exchange bank
// Assumes: one 250 MHz clock, zero based protocol addresses on requests
// Notes: printed register numbers kept as-is, bases derive addresses
package fbm_pkg;

	// Clock and interval timing
	localparam int CLK_PERIOD_PS = 4000;
	localparam int PS_PER_US = 1000000;
	localparam int US_CYCLES = PS_PER_US / CLK_PERIOD_PS;
	localparam int RPI_MIN_MS = 50;
	localparam int US_PER_MS = 1000;
	localparam logic [31:0] RPI_MIN_US = 32'(RPI_MIN_MS * US_PER_MS);

	// Assembly instances
	localparam logic [7:0] ASM_SMALL_OT = 8'h70;
	localparam logic [7:0] ASM_SMALL_TO = 8'h64;
	localparam logic [7:0] ASM_LARGE_OT = 8'h71;
	localparam logic [7:0] ASM_LARGE_TO = 8'h65;

	// Network server port
	localparam logic [15:0] SERVER_PORT = 16'h01F6;

	// Function codes
	localparam logic [7:0] FC_RD_COILS = 8'h01;
	localparam logic [7:0] FC_RD_DISC = 8'h02;
	localparam logic [7:0] FC_RD_HOLD = 8'h03;
	localparam logic [7:0] FC_RD_INPUT = 8'h04;
	localparam logic [7:0] FC_WR_COIL = 8'h05;
	localparam logic [7:0] FC_WR_REG = 8'h06;
	localparam logic [7:0] FC_RD_EXC = 8'h07;
	localparam logic [7:0] FC_WR_MULTI = 8'h10;

	// Exception codes
	localparam logic [7:0] EXC_NONE = 8'h00;
	localparam logic [7:0] EXC_FUNC = 8'h01;
	localparam logic [7:0] EXC_ADDR = 8'h02;
	localparam logic [7:0] EXC_VALUE = 8'h03;

	// Printed register numbers and their bank bases
	localparam logic [15:0] COIL_BASE = 16'h0001;
	localparam logic [15:0] CMD_COIL_REG = 16'h0001;
	localparam logic [15:0] DISC_BASE = 16'h2711;
	localparam logic [15:0] ACK_DISC_REG = 16'h2711;
	localparam logic [15:0] STAT_DISC_REG = 16'h2721;
	localparam logic [15:0] CMD_COIL_ADDR = CMD_COIL_REG - COIL_BASE;
	localparam logic [15:0] ACK_DISC_ADDR = ACK_DISC_REG - DISC_BASE;
	localparam logic [15:0] STAT_DISC_ADDR = STAT_DISC_REG - DISC_BASE;
	localparam logic [15:0] FLAG_BITS = 16'h0010;
	localparam logic [15:0] DISC_BITS = 16'h0020;

	// Word addresses of register banks
	localparam logic [15:0] IN_ACK_WORD = 16'h0000;
	localparam logic [15:0] IN_STAT_WORD = 16'h0001;
	localparam logic [15:0] IN_ERR_LSW = 16'h0002;
	localparam logic [15:0] IN_ERR_MSW = 16'h0003;
	localparam logic [15:0] HOLD_OUT_BASE = 16'h03E8;
	localparam logic [15:0] HOLD_CMD_WORD = 16'h0000;

	// Coil write values
	localparam logic [15:0] COIL_ON = 16'hFF00;
	localparam logic [15:0] COIL_OFF = 16'h0000;

	// Defined bits of command and status words
	localparam logic [15:0] CMD_MASK = 16'h800F;
	localparam logic [15:0] STAT_MASK = 16'hF0EF;
	localparam int CMD_PRODUCT = 0;
	localparam int CMD_LEARN = 1;
	localparam int CMD_TRIGGER = 2;
	localparam int CMD_BARCODE = 3;
	localparam int CMD_EXECUTE = 15;
	localparam int ST_READY = 0;
	localparam int ST_VERDICT = 1;
	localparam int ST_DECODE = 2;
	localparam int ST_ARMED = 3;
	localparam int ST_OUT1 = 5;
	localparam int ST_MISSED = 12;
	localparam int ST_EXEC_ERR = 15;
	localparam logic [15:0] WORD_ZERO = 16'h0000;

	typedef struct packed {
		logic [7:0] func;
		logic [15:0] addr;
		logic [15:0] wdata;
	} fbm_req_type;

	typedef struct packed {
		logic [7:0] func;
		logic [7:0] exc;
		logic [15:0] rdata;
	} fbm_rsp_type;

	typedef struct packed {
		logic cyclic;
		logic [15:0] tcp_port;
		logic [7:0] ot_inst;
		logic [7:0] to_inst;
		logic [31:0] rpi_us;
		logic int16_fmt;
	} fbm_conn_type;

	typedef struct packed {
		logic [15:0] w0;
		logic [15:0] w1;
		logic [15:0] w2;
		logic [15:0] w3;
	} fbm_cyc_type;

endpackage

// [verilog/fbm_ack_cell.sv]
// Purpose: one acknowledge flag following its command flag
// Assumes: done is a one cycle pulse from the inspection core
// Notes: done without a raised command is ignored
module fbm_ack_cell
	import fbm_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Handshake
	input wire logic cmd,
	input wire logic done,
	output logic ack
);

	logic ack_reg;
	logic ack_next;

	always_comb begin
		ack_next = ack_reg;
		// set after done, drop with command
		if (!cmd) begin
			ack_next = 1'b0;
		end else if (done) begin
			ack_next = 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= ack_next;
		end
	end

	assign ack = ack_reg;

endmodule // fbm_ack_cell

// [verilog/fbm_flag_bank.sv]
// Purpose: command, acknowledge and status flag bank for the network side
// Assumes: requests and core signals are on clk_sys, one item per request
// Notes: multi register writes arrive as one request per word
//
// Summary of operation
// - Cyclic packet intervals down to 50 ms accepted, shorter ones refused.
// - Small grouping uses instance 112 outbound and 100 inbound.
// - Large grouping uses instance 113 outbound and 101 inbound.
// - Network server accepts client connections on TCP port 502.
// - Output words read alike as input registers and as holding registers.
// - Single coil write sets or clears the matching command bit.
// - Acknowledge and status bits read as discrete inputs.
// - Function codes 01 to 07 and 16 are served.
// - Coils 1 to 16 are command bits; undefined bits stay zero.
// - Discrete inputs 10001-10016 carry acknowledge bits like commands.
// - Discrete inputs 10017-10032 carry status bits; reserved read zero.
// - Output words 0 and 1 carry acknowledge and status words.
// - 32-bit values go low word first, high word second.
module fbm_flag_bank
	import fbm_pkg::*;
#(
	parameter int FLAGS = 16
)
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Request and answer
	input wire logic req_valid,
	output logic req_ready,
	input wire fbm_req_type req,
	output logic rsp_valid,
	input wire logic rsp_ready,
	output fbm_rsp_type rsp,
	// Connection setup
	input wire logic conn_valid,
	input wire fbm_conn_type conn,
	input wire logic conn_close,
	output logic conn_accept,
	output logic conn_reject,
	output logic conn_open,
	output logic conn_large,
	// Cyclic exchange
	input wire logic ot_valid,
	input wire logic [15:0] ot_word0,
	output logic to_valid,
	output fbm_cyc_type to_data,
	// Inspection core
	output logic [FLAGS-1:0] cmd_bits,
	output logic [FLAGS-1:0] cmd_start,
	input wire logic [FLAGS-1:0] cmd_done,
	input wire logic [15:0] status_in,
	input wire logic [31:0] error_code
);

	if (FLAGS != 16) begin : g_bad_width
		$error("fbm_flag_bank serves 16 flag bits only");
	end

	typedef enum logic [1:0] {
		CONN_IDLE,
		CONN_SERVER,
		CONN_CYCLIC
	} fbm_conn_state_type;

	fbm_conn_state_type conn_reg, conn_next;
	logic large_reg, large_next;
	logic accept_reg, accept_next;
	logic reject_reg, reject_next;
	logic [31:0] rpi_reg, rpi_next;
	logic [15:0] cmd_reg, cmd_next;
	logic [15:0] cmd_prev_reg;
	logic rsp_valid_reg, rsp_valid_next;
	fbm_rsp_type rsp_reg, rsp_next;
	logic [7:0] us_cnt_reg, us_cnt_next;
	logic [31:0] int_cnt_reg, int_cnt_next;
	logic to_valid_reg, to_valid_next;
	fbm_cyc_type to_reg, to_next;
	logic [15:0] ack_word;
	logic [15:0] stat_word;
	logic [31:0] disc_bits;
	logic take;
	logic us_tick;
	logic pair_small;
	logic pair_large;

	for (genvar i = 0; i < FLAGS; i++) begin : g_ack
		fbm_ack_cell u_cell (
			.clk_sys(clk_sys),
			.rst_n(rst_n),
			.cmd(cmd_reg[i]),
			.done(cmd_done[i] & CMD_MASK[i]),
			.ack(ack_word[i])
		);
	end

	assign stat_word = status_in & STAT_MASK;
	// ack bits low, status bits high
	assign disc_bits = {stat_word, ack_word};
	assign req_ready = !rsp_valid_reg || rsp_ready;
	assign take = req_valid && req_ready;
	assign pair_small = conn.ot_inst == ASM_SMALL_OT
		&& conn.to_inst == ASM_SMALL_TO;
	assign pair_large = conn.ot_inst == ASM_LARGE_OT
		&& conn.to_inst == ASM_LARGE_TO;

	// Connection handling
	always_comb begin
		conn_next = conn_reg;
		large_next = large_reg;
		rpi_next = rpi_reg;
		accept_next = 1'b0;
		reject_next = 1'b0;
		if (conn_close) begin
			conn_next = CONN_IDLE;
		end else if (conn_valid) begin
			if (!conn.cyclic) begin
				// only the server port is taken
				if (conn.tcp_port == SERVER_PORT) begin
					accept_next = 1'b1;
					conn_next = CONN_SERVER;
				end else begin
					reject_next = 1'b1;
				end
			end else if ((pair_small || pair_large) && conn.int16_fmt
				&& conn.rpi_us >= RPI_MIN_US) begin
				accept_next = 1'b1;
				conn_next = CONN_CYCLIC;
				large_next = pair_large;
				rpi_next = conn.rpi_us;
			end else begin
				reject_next = 1'b1;
			end
		end
	end

	// Command word and request decode
	always_comb begin
		logic [15:0] w;
		w = req.addr;
		cmd_next = cmd_reg;
		rsp_valid_next = rsp_valid_reg && !rsp_ready;
		rsp_next = rsp_reg;
		if (take) begin
			rsp_valid_next = 1'b1;
			rsp_next.func = req.func;
			rsp_next.exc = EXC_NONE;
			rsp_next.rdata = WORD_ZERO;
			unique case (req.func)
				FC_RD_COILS: begin
					if (req.addr < FLAG_BITS) begin
						rsp_next.rdata = cmd_reg >> req.addr[3:0];
					end else begin
						rsp_next.exc = EXC_ADDR;
					end
				end
				FC_RD_DISC: begin
					if (req.addr < DISC_BITS) begin
						rsp_next.rdata = 16'(disc_bits >> req.addr[4:0]);
					end else begin
						rsp_next.exc = EXC_ADDR;
					end
				end
				FC_RD_HOLD, FC_RD_INPUT: begin
					if (req.func == FC_RD_HOLD) begin
						w = req.addr - HOLD_OUT_BASE;
					end
					if (req.func == FC_RD_HOLD && req.addr == HOLD_CMD_WORD) begin
						rsp_next.rdata = cmd_reg;
					end else if (w == IN_ACK_WORD) begin
						rsp_next.rdata = ack_word;
					end else if (w == IN_STAT_WORD) begin
						rsp_next.rdata = stat_word;
					end else if (w == IN_ERR_LSW) begin
						rsp_next.rdata = error_code[15:0];
					end else if (w == IN_ERR_MSW) begin
						rsp_next.rdata = error_code[31:16];
					end else begin
						rsp_next.exc = EXC_ADDR;
					end
				end
				FC_WR_COIL: begin
					if (req.addr >= FLAG_BITS) begin
						rsp_next.exc = EXC_ADDR;
					end else if (req.wdata == COIL_ON) begin
						cmd_next[req.addr[3:0]] = CMD_MASK[req.addr[3:0]];
						rsp_next.rdata = req.wdata;
					end else if (req.wdata == COIL_OFF) begin
						cmd_next[req.addr[3:0]] = 1'b0;
						rsp_next.rdata = req.wdata;
					end else begin
						rsp_next.exc = EXC_VALUE;
					end
				end
				FC_WR_REG, FC_WR_MULTI: begin
					if (req.addr == HOLD_CMD_WORD) begin
						cmd_next = req.wdata & CMD_MASK;
						rsp_next.rdata = req.wdata;
					end else begin
						rsp_next.exc = EXC_ADDR;
					end
				end
				FC_RD_EXC: begin
					rsp_next.rdata = {8'h00, stat_word[7:0]};
				end
				default: begin
					rsp_next.exc = EXC_FUNC;
				end
			endcase
		end
		// Cyclic word lands last so it wins a same cycle clash
		if (ot_valid && conn_reg == CONN_CYCLIC) begin
			cmd_next = ot_word0 & CMD_MASK;
		end
	end

	// Produce the inbound cyclic packet once per interval
	always_comb begin
		us_tick = us_cnt_reg == 8'(US_CYCLES - 1);
		us_cnt_next = us_tick ? 8'h00 : us_cnt_reg + 8'h01;
		int_cnt_next = int_cnt_reg;
		to_valid_next = 1'b0;
		to_next = to_reg;
		if (conn_reg != CONN_CYCLIC) begin
			int_cnt_next = 32'h0000_0000;
		end else if (us_tick) begin
			if (int_cnt_reg >= rpi_reg - 32'h0000_0001) begin
				int_cnt_next = 32'h0000_0000;
				to_valid_next = 1'b1;
				// words 0 and 1 carry flag words
				to_next.w0 = ack_word;
				to_next.w1 = stat_word;
				to_next.w2 = error_code[15:0];
				to_next.w3 = error_code[31:16];
			end else begin
				int_cnt_next = int_cnt_reg + 32'h0000_0001;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			conn_reg <= CONN_IDLE;
			large_reg <= 1'b0;
			accept_reg <= 1'b0;
			reject_reg <= 1'b0;
			rpi_reg <= RPI_MIN_US;
			cmd_reg <= WORD_ZERO;
			cmd_prev_reg <= WORD_ZERO;
			rsp_valid_reg <= 1'b0;
			rsp_reg <= '0;
			us_cnt_reg <= 8'h00;
			int_cnt_reg <= 32'h0000_0000;
			to_valid_reg <= 1'b0;
			to_reg <= '0;
		end else begin
			conn_reg <= conn_next;
			large_reg <= large_next;
			accept_reg <= accept_next;
			reject_reg <= reject_next;
			rpi_reg <= rpi_next;
			cmd_reg <= cmd_next;
			cmd_prev_reg <= cmd_reg;
			rsp_valid_reg <= rsp_valid_next;
			rsp_reg <= rsp_next;
			us_cnt_reg <= us_cnt_next;
			int_cnt_reg <= int_cnt_next;
			to_valid_reg <= to_valid_next;
			to_reg <= to_next;
		end
	end

	assign conn_accept = accept_reg;
	assign conn_reject = reject_reg;
	assign conn_open = conn_reg != CONN_IDLE;
	assign conn_large = large_reg;
	assign rsp_valid = rsp_valid_reg;
	assign rsp = rsp_reg;
	assign to_valid = to_valid_reg;
	assign to_data = to_reg;
	assign cmd_bits = cmd_reg;
	assign cmd_start = cmd_reg & ~cmd_prev_reg;

endmodule // fbm_flag_bank

// [tb/fbm_flag_bank_assertions.sv]
// Purpose: port checks for the flag bank
// Assumes: FLAGS is 16
// Notes: cyclic interval timing left to long runs
module fbm_flag_bank_assertions
	import fbm_pkg::*;
#(parameter int FLAGS = 16)
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Bus
	input wire logic req_valid,
	input wire logic req_ready,
	input wire fbm_req_type req,
	input wire logic rsp_valid,
	input wire logic ot_valid,
	// Connection
	input wire logic conn_valid,
	input wire fbm_conn_type conn,
	input wire logic conn_close,
	input wire logic conn_accept,
	input wire logic conn_reject,
	input wire logic conn_large,
	// Core
	input wire logic [FLAGS-1:0] cmd_bits,
	input wire logic [FLAGS-1:0] cmd_start
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	sequence take_s;
		req_valid && req_ready;
	endsequence
	sequence coil_s;
		take_s ##0 (req.func == FC_WR_COIL && req.addr < FLAG_BITS && !ot_valid);
	endsequence
	sequence cyc_s;
		conn_valid && !conn_close && conn.cyclic && conn.int16_fmt
			&& conn.rpi_us >= RPI_MIN_US;
	endsequence
	a_rsp_after_take: assert property (take_s |=> rsp_valid)
		else $error("answer missing after take");
	a_coil_sets: assert property (coil_s ##0 (req.wdata == COIL_ON
		&& CMD_MASK[req.addr[3:0]]) |=> cmd_bits[$past(req.addr[3:0])])
		else $error("coil on not applied");
	a_coil_clears: assert property (coil_s ##0 req.wdata == COIL_OFF
		|=> !cmd_bits[$past(req.addr[3:0])])
		else $error("coil off not applied");
	a_cmd_reserved: assert property ((cmd_bits & ~CMD_MASK) == '0)
		else $error("reserved command bit set");
	a_start_rise: assert property (
		cmd_start == (cmd_bits & ~$past(cmd_bits)))
		else $error("start pulse not on rising bit");
	a_small_pair: assert property (cyc_s ##0 (conn.ot_inst == ASM_SMALL_OT
		&& conn.to_inst == ASM_SMALL_TO) |=> conn_accept && !conn_large)
		else $error("small pair not accepted");
	a_large_pair: assert property (cyc_s ##0 (conn.ot_inst == ASM_LARGE_OT
		&& conn.to_inst == ASM_LARGE_TO) |=> conn_accept && conn_large)
		else $error("large pair not accepted");
	a_rpi_floor: assert property (conn_valid && !conn_close && conn.cyclic
		&& conn.rpi_us < RPI_MIN_US |=> conn_reject)
		else $error("short interval accepted");
	a_server_port: assert property (conn_valid && !conn_close && !conn.cyclic
		|=> conn_accept == ($past(conn.tcp_port) == SERVER_PORT))
		else $error("server port decision wrong");
endmodule // fbm_flag_bank_assertions

bind fbm_flag_bank fbm_flag_bank_assertions #(.FLAGS(FLAGS)) u_chk (
	.clk_sys(clk_sys), .rst_n(rst_n), .req_valid(req_valid),
	.req_ready(req_ready), .req(req), .rsp_valid(rsp_valid),
	.ot_valid(ot_valid), .conn_valid(conn_valid), .conn(conn),
	.conn_close(conn_close), .conn_accept(conn_accept),
	.conn_reject(conn_reject), .conn_large(conn_large),
	.cmd_bits(cmd_bits), .cmd_start(cmd_start));

// [tb/fbm_core_model.sv]
// Purpose: inspection core answering command starts
// Assumes: one command in flight, newest start wins
// Notes: slow mode stretches the reply to test waiting
module fbm_core_model
	import fbm_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic slow,
	input wire logic [15:0] cmd_start,
	output logic [15:0] cmd_done
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] pend;
	logic [3:0] cnt;
	always @(posedge clk_sys) begin
		cmd_done <= '0;
		if (!rst_n) begin
			cnt <= '0;
		end else if (cmd_start != '0) begin
			pend <= cmd_start;
			cnt <= slow ? 4'hC : 4'h2;
		end else if (cnt != '0) begin
			cnt <= cnt - 4'h1;
			if (cnt == 4'h1) cmd_done <= pend;
		end
	end
endmodule // fbm_core_model

// [tb/tb.sv]
// Purpose: self checking bench for the flag bank
// Assumes: answers always consumed at once
// Notes: cyclic intervals too long to run here
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import fbm_pkg::*;
	logic clk_sys, rst_n, req_valid, req_ready, rsp_valid, rsp_ready;
	logic conn_valid, conn_accept, conn_reject, conn_large, slow;
	logic conn_close, conn_open, ot_valid;
	logic [15:0] ot_word0, ow;
	fbm_req_type req;
	fbm_rsp_type rsp, e;
	fbm_conn_type conn;
	logic [15:0] cmd_bits, cmd_start, cmd_done, status_in, st;
	logic [31:0] error_code, er;
	logic [2:0] c;
	int error_cnt, tests_run;
	fbm_rsp_type rq[$];
	logic [2:0] cq[$];

	fbm_flag_bank DUT (.clk_sys(clk_sys), .rst_n(rst_n),
		.req_valid(req_valid), .req_ready(req_ready), .req(req),
		.rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp(rsp),
		.conn_valid(conn_valid), .conn(conn), .conn_close(conn_close),
		.conn_accept(conn_accept), .conn_reject(conn_reject),
		.conn_open(conn_open), .conn_large(conn_large),
		.ot_valid(ot_valid), .ot_word0(ot_word0), .to_valid(), .to_data(),
		.cmd_bits(cmd_bits), .cmd_start(cmd_start), .cmd_done(cmd_done),
		.status_in(status_in), .error_code(error_code));
	fbm_core_model u_core (.clk_sys(clk_sys), .rst_n(rst_n), .slow(slow),
		.cmd_start(cmd_start), .cmd_done(cmd_done));

	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	task automatic check(input string nm, input logic [31:0] s, x);
		tests_run++;
		if (s !== x) begin
			error_cnt++;
			$display("unexpected %s exp %h seen %h", nm, x, s);
		end
	endtask

	task automatic summarize;
		if (error_cnt == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	task automatic xfer(input logic [7:0] f, input logic [15:0] a, d,
		input logic [7:0] x, input logic [15:0] r);
		rq.push_back('{f, x, r});
		req <= '{f, a, d};
		req_valid <= 1'b1;
		@(posedge clk_sys);
		req_valid <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic cn(input logic y, input logic [15:0] p,
		input logic [7:0] o, t, input logic [31:0] i, input logic f,
		input logic [2:0] x);
		cq.push_back(x);
		conn <= '{y, p, o, t, i, f};
		conn_valid <= 1'b1;
		@(posedge clk_sys);
		conn_valid <= 1'b0;
		repeat (2) @(posedge clk_sys);
	endtask

	always @(negedge clk_sys) begin
		if (rsp_valid === 1'b1) begin
			e = rq.pop_front();
			check("func", rsp.func, e.func);
			check("exc", rsp.exc, e.exc);
			if (e.exc == EXC_NONE)
				check("rdata", rsp.rdata, e.rdata);
		end
		if (conn_accept === 1'b1 || conn_reject === 1'b1) begin
			c = cq.pop_front();
			check("conn", {conn_accept, conn_large, conn_open}, c);
		end
	end

	initial begin
		rst_n = 1'b0;
		req_valid = 1'b0;
		req = '0;
		rsp_ready = 1'b1;
		conn_valid = 1'b0;
		conn = '0;
		conn_close = 1'b0;
		ot_valid = 1'b0;
		ot_word0 = '0;
		slow = 1'b0;
		status_in = '0;
		error_code = '0;
		error_cnt = 0;
		tests_run = 0;
		void'($urandom(32'hE66B));
		st = 16'($urandom);
		er = $urandom;
		repeat (5) @(posedge clk_sys);
		rst_n <= 1'b1;
		status_in <= st;
		error_code <= er;
		for (int i = 0; i < 16; i++)
			xfer(FC_WR_COIL, 16'(i), COIL_ON, EXC_NONE, COIL_ON);
		xfer(FC_RD_COILS, 16'h0000, 16'h0000, EXC_NONE, CMD_MASK);
		xfer(FC_RD_HOLD, HOLD_CMD_WORD, 16'h0000, EXC_NONE, CMD_MASK);
		xfer(FC_WR_REG, HOLD_CMD_WORD, 16'h0000, EXC_NONE, 16'h0000);
		xfer(FC_WR_MULTI, HOLD_CMD_WORD, 16'hFFFF, EXC_NONE, 16'hFFFF);
		xfer(FC_RD_COILS, 16'h000F, 16'h0000, EXC_NONE, 16'h0001);
		xfer(FC_WR_REG, HOLD_CMD_WORD, 16'h0000, EXC_NONE, 16'h0000);
		slow <= 1'b1;
		repeat (20) @(posedge clk_sys);
		xfer(FC_WR_COIL, 16'h0002, COIL_ON, EXC_NONE, COIL_ON);
		xfer(FC_RD_DISC, ACK_DISC_ADDR, 16'h0000, EXC_NONE, 16'h0000);
		repeat (16) @(posedge clk_sys);
		xfer(FC_RD_DISC, ACK_DISC_ADDR, 16'h0000, EXC_NONE, 16'h0004);
		xfer(FC_WR_COIL, 16'h0002, COIL_OFF, EXC_NONE, COIL_OFF);
		repeat (2) @(posedge clk_sys);
		xfer(FC_RD_DISC, ACK_DISC_ADDR, 16'h0000, EXC_NONE, 16'h0000);
		xfer(FC_RD_DISC, STAT_DISC_ADDR, 16'h0000, EXC_NONE, st & STAT_MASK);
		xfer(FC_RD_INPUT, IN_STAT_WORD, 16'h0000, EXC_NONE, st & STAT_MASK);
		xfer(FC_RD_HOLD, HOLD_OUT_BASE + IN_STAT_WORD, 16'h0000, EXC_NONE,
			st & STAT_MASK);
		xfer(FC_RD_INPUT, IN_ERR_LSW, 16'h0000, EXC_NONE, er[15:0]);
		xfer(FC_RD_HOLD, HOLD_OUT_BASE + IN_ERR_MSW, 16'h0000, EXC_NONE,
			er[31:16]);
		xfer(FC_RD_EXC, 16'h0000, 16'h0000, EXC_NONE,
			16'(st[7:0] & STAT_MASK[7:0]));
		xfer(8'h08, 16'h0000, 16'h0000, EXC_FUNC, 16'h0000);
		xfer(FC_WR_COIL, 16'h0000, 16'h1234, EXC_VALUE, 16'h0000);
		xfer(FC_WR_COIL, FLAG_BITS, COIL_ON, EXC_ADDR, 16'h0000);
		cn(1'b0, SERVER_PORT, 8'h00, 8'h00, 32'h0, 1'b0, 3'b101);
		cn(1'b0, 16'h01F7, 8'h00, 8'h00, 32'h0, 1'b0, 3'b001);
		cn(1'b1, 16'h0000, ASM_SMALL_OT, ASM_SMALL_TO, RPI_MIN_US, 1'b1,
			3'b101);
		cn(1'b1, 16'h0000, ASM_LARGE_OT, ASM_LARGE_TO, RPI_MIN_US, 1'b1,
			3'b111);
		cn(1'b1, 16'h0000, ASM_SMALL_OT, ASM_SMALL_TO, RPI_MIN_US - 32'h1,
			1'b1, 3'b011);
		cn(1'b1, 16'h0000, ASM_SMALL_OT, ASM_SMALL_TO, RPI_MIN_US, 1'b0,
			3'b011);
		cn(1'b1, 16'h0000, ASM_SMALL_OT, ASM_LARGE_TO, RPI_MIN_US, 1'b1,
			3'b011);
		// Cyclic command word lands only while the link is open
		ow = 16'($urandom);
		ot_word0 <= ow;
		ot_valid <= 1'b1;
		@(posedge clk_sys);
		ot_valid <= 1'b0;
		xfer(FC_RD_COILS, 16'h0000, 16'h0000, EXC_NONE, ow & CMD_MASK);
		conn_close <= 1'b1;
		@(posedge clk_sys);
		conn_close <= 1'b0;
		cn(1'b0, 16'h01F7, 8'h00, 8'h00, 32'h0, 1'b0, 3'b010);
		ot_word0 <= ~ow;
		ot_valid <= 1'b1;
		@(posedge clk_sys);
		ot_valid <= 1'b0;
		xfer(FC_RD_COILS, 16'h0000, 16'h0000, EXC_NONE, ow & CMD_MASK);
		for (int i = 0; i < 20 && rq.size() > 0; i++) @(posedge clk_sys);
		check("drain", rq.size() + cq.size(), 0);
		summarize();
	end
endmodule // tb
